// file: hdl/usas_defs.svh
// Constants for the audio serial interface with streaming rate control.
`ifndef USAS_DEFS_SVH
`define USAS_DEFS_SVH
`define USAS_REG_CTRL      8'h00
`define USAS_REG_LOW_MARK  8'h04
`define USAS_REG_HIGH_MARK 8'h08
`define USAS_REG_LARGE_LEN 8'h0c
`define USAS_REG_NORM_LEN  8'h10
`define USAS_REG_SMALL_LEN 8'h14
`define USAS_REG_STATUS    8'h18
`define USAS_REG_SOF_SUM   8'h1c
`define USAS_REG_STEP      8'h20
`define USAS_RESP_OKAY     2'h0
`define USAS_RESP_SLVERR   2'h2
`define USAS_PF_AUDIO      2'h1
`define USAS_LOW_RST       7'h10
`define USAS_HIGH_RST      7'h30
`define USAS_LARGE_RST     8'h62
`define USAS_NORM_RST      8'h60
`define USAS_SMALL_RST     8'h5e
`define USAS_FIFO_AW       6
`define USAS_SAMPLE_W      16
`define USAS_NOM_STEP      32'h1f75104d
`define USAS_TRIM_UNIT     32'h0000ce29
`define USAS_TRIM_MAX      8'sh40
`define USAS_SYNC_GAIN     9'h0a5
`define USAS_CLK_PERIOD_NS 5
`define USAS_SOF_PERIOD_NS 1000000
`define USAS_SOF_FR_LOG2   4
`define USAS_BIT_LAST      4'hf
`define USAS_BIT_MID       4'h7
`endif

// file: hdl/usas_pkg.sv
// Types shared by the audio serial interface modules.
package usas_pkg;
  typedef enum logic [1:0] {
    USAS_SYNC_ASYNC,
    USAS_SYNC_SYNC,
    USAS_SYNC_ADAPT
  } usas_sync_e;
  typedef enum logic [1:0] {
    USAS_BAND_LOW,
    USAS_BAND_MID,
    USAS_BAND_HIGH
  } usas_band_e;
  typedef struct packed {
    logic [1:0] pin_func;
    usas_sync_e sync;
    logic       transmit;
    logic       enable;
  } usas_ctrl_s;
  typedef struct packed {
    logic [6:0] fifo_low_water_mark;
    logic [6:0] fifo_high_water_mark;
    logic [7:0] large_packet_length;
    logic [7:0] normal_packet_length;
    logic [7:0] small_packet_length;
  } usas_cfg_s;
endpackage

// file: hdl/usas_clock_gen.sv
// Sampling clock generator: phase accumulator driving master, bit and word clocks.
`timescale 1ns/1ps
`include "usas_defs.svh"
module usas_clock_gen
  import usas_pkg::*;
(
  input  wire logic        aclk,       // System clock.
  input  wire logic        aresetn,    // Synchronous reset, active low.
  input  wire logic        run,        // Generator runs while high.
  input  wire logic [31:0] step,       // Phase increment per aclk.
  output logic             mclk,       // Master clock, 256 fs.
  output logic             bclk,       // Bit clock, 32 fs.
  output logic             lrck,       // Word clock, fs.
  output logic             bit_shift,  // Pulse at bit clock fall.
  output logic             bit_sample, // Pulse at bit clock rise.
  output logic             slot_start  // Pulse at first bit of a slot.
);
  logic [31:0] acc;
  logic [8:0]  cnt;
  logic [32:0] sum;
  logic        tick;

  assign sum  = {1'b0, acc} + {1'b0, step};
  assign tick = sum[32];

  // Each carry is half a master clock period; 512 carries make one sample.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      acc <= 32'h0;
      cnt <= 9'h0;
    end
    else
    begin
      acc <= sum[31:0];
      if (tick)
        cnt <= cnt + 9'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      mclk       <= 1'b0;
      bclk       <= 1'b0;
      lrck       <= 1'b0;
      bit_shift  <= 1'b0;
      bit_sample <= 1'b0;
      slot_start <= 1'b0;
    end
    else
    begin
      mclk       <= cnt[0];
      bclk       <= cnt[3];
      lrck       <= cnt[8];
      bit_shift  <= tick && (cnt[3:0] == `USAS_BIT_LAST);
      bit_sample <= tick && (cnt[3:0] == `USAS_BIT_MID);
      slot_start <= tick && (cnt[7:0] == 8'hff);
    end
  end
endmodule

// file: hdl/usas_top.sv
// Audio serial interface with FIFO-driven packet sizing and sampling clock control.
// Operation
// R01 - Provide serial in, serial out, bit, word, master clocks and mic detect.
// R02 - Serial out drives only when transmitting; serial in read only when receiving.
// R03 - Interface runs only when pin function selects the audio setting.
// R04 - Asynchronous, synchronous and adaptive synchronisation types all supported.
// R05 - Controller should choose async capture, adaptive playback, 48 kHz, 16-bit stereo.
// R06 - Async capture runs sampling clock at fixed nominal 48 kHz, never adjusted.
// R07 - Async capture writes codec samples into input FIFO checked against marks.
// R08 - Per frame send large, normal or small packet by input FIFO fill.
// R09 - Host absorbs varying capture amount per frame; device does not compensate.
// R10 - Adaptive playback starts at nominal 48 kHz and buffers host data.
// R11 - Host sends equal data each frame for 48 kHz on host clock.
// R12 - Adaptive playback raises clock above high mark, lowers below low mark.
// R13 - Synchronous mode locks audio clock to host start-of-frame tokens.
// R14 - Start-of-frame timing measured over many frames to average jitter.
// R15 - Synchronous mode derives sampling clock from measured host frame rate.
// R16 - FIFO fill compared with marks once per frame, at start-of-frame.
// R17 - Marks and packet lengths programmable, taking effect next frame.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "usas_defs.svh"
module usas_top
  import usas_pkg::*;
#(
  parameter int SOF_NOMINAL_CYCLES = `USAS_SOF_PERIOD_NS / `USAS_CLK_PERIOD_NS
)
(
  input  wire logic        aclk,                   // Clock, 200 MHz.
  input  wire logic        aresetn,                // Synchronous reset, active low.
  input  wire logic [7:0]  s_axi_awaddr,           // Write address.
  input  wire logic        s_axi_awvalid,          // Write address valid.
  output logic             s_axi_awready,          // Write address ready.
  input  wire logic [31:0] s_axi_wdata,            // Write data.
  input  wire logic [3:0]  s_axi_wstrb,            // Write byte strobes.
  input  wire logic        s_axi_wvalid,           // Write data valid.
  output logic             s_axi_wready,           // Write data ready.
  output logic [1:0]       s_axi_bresp,            // Write response.
  output logic             s_axi_bvalid,           // Write response valid.
  input  wire logic        s_axi_bready,           // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,           // Read address.
  input  wire logic        s_axi_arvalid,          // Read address valid.
  output logic             s_axi_arready,          // Read address ready.
  output logic [31:0]      s_axi_rdata,            // Read data.
  output logic [1:0]       s_axi_rresp,            // Read response.
  output logic             s_axi_rvalid,           // Read data valid.
  input  wire logic        s_axi_rready,           // Read data ready.
  input  wire logic        sof,                    // Host start-of-frame pulse.
  output logic [15:0]      in_data,                // Capture sample to host.
  output logic             in_valid,               // Capture sample valid.
  input  wire logic        in_ready,               // Host takes capture sample.
  output logic [7:0]       in_frame_length,        // Samples granted this frame.
  input  wire logic [15:0] out_data,               // Playback sample from host.
  input  wire logic        out_valid,              // Playback sample valid.
  output logic             out_ready,              // Playback FIFO has room.
  input  wire logic        audio_serial_in,        // Serial data from codec.
  output logic             audio_serial_out,       // Serial data to codec.
  output logic             audio_serial_out_oe_n,  // Serial out enable, active low.
  output logic             audio_bit_clock,        // Serial bit clock.
  output logic             audio_word_clock,       // Left/right word clock.
  output logic             audio_master_clock,     // Codec master clock.
  input  wire logic        microphone_plug_detect, // Microphone plug pin.
  output logic             mic_present             // Debounced plug state.
);
  localparam int          FD = 1 << `USAS_FIFO_AW;
  localparam logic [23:0] SOF_WINDOW =
    24'(SOF_NOMINAL_CYCLES * (1 << `USAS_SOF_FR_LOG2));

  usas_ctrl_s  ctrl;
  usas_cfg_s   cfg;
  usas_band_e  in_band;
  usas_band_e  out_band;
  logic        active;
  logic        tx_mode;
  logic        rx_mode;
  logic [31:0] step;
  logic [31:0] next_step;
  logic signed [7:0] trim;
  logic [7:0]  budget;
  logic [23:0] win_cnt;
  logic [23:0] sof_sum;
  logic [3:0]  fr_cnt;
  logic        sof_seen;
  logic        sum_valid;

  function automatic usas_band_e classify(input logic [6:0] lvl,
                                          input logic [6:0] low,
                                          input logic [6:0] high);
    if (lvl > high)
      return USAS_BAND_HIGH;
    else if (lvl < low)
      return USAS_BAND_LOW;
    else
      return USAS_BAND_MID;
  endfunction

  // Pin synchronisers: a new level is taken once stages two and three agree.
  logic [2:0] pin_ff [2];
  logic       pin_in [2];
  logic       pin_st [2];
  assign pin_in[0] = audio_serial_in;
  assign pin_in[1] = microphone_plug_detect;
  for (genvar p = 0; p < 2; p++)
  begin : g_sync
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        pin_ff[p] <= 3'h0;
        pin_st[p] <= 1'b0;
      end
      else
      begin
        pin_ff[p] <= {pin_ff[p][1:0], pin_in[p]};
        if (pin_ff[p][1] == pin_ff[p][2])
          pin_st[p] <= pin_ff[p][2];
      end
    end
  end
  assign mic_present = pin_st[1]; // R01

  assign active  = ctrl.enable && (ctrl.pin_func == `USAS_PF_AUDIO); // R03
  assign tx_mode = active && ctrl.transmit; // R02
  assign rx_mode = active && !ctrl.transmit; // R02

  // FIFOs: index 0 carries capture data, index 1 carries playback data.
  logic [15:0]             mem   [2][FD];
  logic [`USAS_FIFO_AW:0]  wr_p  [2];
  logic [`USAS_FIFO_AW:0]  rd_p  [2];
  logic [`USAS_FIFO_AW:0]  level [2];
  logic                    push  [2];
  logic                    pop   [2];
  logic [15:0]             wdat  [2];
  logic [15:0]             rdat  [2];
  logic                    full  [2];
  logic                    empty [2];
  for (genvar f = 0; f < 2; f++)
  begin : g_fifo
    assign level[f] = wr_p[f] - rd_p[f];
    assign full[f]  = level[f][`USAS_FIFO_AW];
    assign empty[f] = (level[f] == '0);
    assign rdat[f]  = mem[f][rd_p[f][`USAS_FIFO_AW-1:0]];
    always_ff @(posedge aclk)
    begin
      if (push[f])
        mem[f][wr_p[f][`USAS_FIFO_AW-1:0]] <= wdat[f];
    end
    always_ff @(posedge aclk)
    begin
      if (!aresetn || !active)
      begin
        wr_p[f] <= '0;
        rd_p[f] <= '0;
      end
      else
      begin
        if (push[f])
          wr_p[f] <= wr_p[f] + 1'b1;
        if (pop[f])
          rd_p[f] <= rd_p[f] + 1'b1;
      end
    end
  end

  // Serial engine.
  logic        bit_shift;
  logic        bit_sample;
  logic        slot_start;
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [3:0]  rx_cnt;
  logic        rx_done;

  usas_clock_gen u_clk (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .run        (active),
    .step       (step),
    .mclk       (audio_master_clock),
    .bclk       (audio_bit_clock),
    .lrck       (audio_word_clock),
    .bit_shift  (bit_shift),
    .bit_sample (bit_sample),
    .slot_start (slot_start)
  );

  assign audio_serial_out_oe_n = !tx_mode; // R02
  assign wdat[1] = out_data;
  assign push[1] = out_valid && out_ready;
  assign out_ready = tx_mode && !full[1]; // R10
  assign pop[1]  = tx_mode && slot_start && !empty[1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_mode)
    begin
      tx_sh            <= 16'h0;
      audio_serial_out <= 1'b0;
    end
    else if (slot_start)
    begin
      // An empty FIFO plays silence rather than stale data.
      tx_sh            <= empty[1] ? 16'h0 : {rdat[1][14:0], 1'b0};
      audio_serial_out <= !empty[1] && rdat[1][15];
    end
    else if (bit_shift)
    begin
      tx_sh            <= {tx_sh[14:0], 1'b0};
      audio_serial_out <= tx_sh[15];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_mode)
    begin
      rx_sh   <= 16'h0;
      rx_cnt  <= 4'h0;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= bit_sample && (rx_cnt == `USAS_BIT_LAST);
      if (slot_start)
        rx_cnt <= 4'h0;
      else if (bit_sample)
      begin
        rx_sh  <= {rx_sh[14:0], pin_st[0]};
        rx_cnt <= rx_cnt + 4'h1;
      end
    end
  end

  // Samples arriving to a full input FIFO are dropped.
  assign wdat[0] = rx_sh;
  assign push[0] = rx_done && !full[0]; // R07
  assign in_data  = rdat[0];
  assign in_valid = rx_mode && !empty[0] && (budget != 8'h0); // R08
  assign pop[0]   = in_valid && in_ready;

  assign in_band  = classify(level[0], cfg.fifo_low_water_mark,
                             cfg.fifo_high_water_mark);
  assign out_band = classify(level[1], cfg.fifo_low_water_mark,
                             cfg.fifo_high_water_mark);

  // Packet size is chosen once per frame from live settings.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_mode)
    begin
      in_frame_length <= 8'h0;
      budget          <= 8'h0;
    end
    else if (sof) // R16
    begin
      case (in_band) // R08
        USAS_BAND_HIGH:
        begin
          in_frame_length <= cfg.large_packet_length; // R17
          budget          <= cfg.large_packet_length;
        end
        USAS_BAND_LOW:
        begin
          in_frame_length <= cfg.small_packet_length;
          budget          <= cfg.small_packet_length;
        end
        default:
        begin
          in_frame_length <= cfg.normal_packet_length;
          budget          <= cfg.normal_packet_length;
        end
      endcase
    end
    else if (pop[0])
      budget <= budget - 8'h1;
  end

  // Adaptive trim moves one unit per frame and saturates.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_mode || ctrl.sync != USAS_SYNC_ADAPT)
      trim <= 8'sh0; // R10
    else if (sof) // R16
    begin
      if (out_band == USAS_BAND_HIGH && trim < `USAS_TRIM_MAX)
        trim <= trim + 8'sh1; // R12
      else if (out_band == USAS_BAND_LOW && trim > -`USAS_TRIM_MAX)
        trim <= trim - 8'sh1; // R12
    end
  end

  // Frame timing is summed over sixteen frames to average out jitter.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      win_cnt   <= 24'h0;
      fr_cnt    <= 4'h0;
      sof_seen  <= 1'b0;
      sof_sum   <= 24'h0;
      sum_valid <= 1'b0;
    end
    else if (sof) // R13
    begin
      sof_seen <= 1'b1;
      fr_cnt   <= fr_cnt + 4'h1;
      if (fr_cnt == `USAS_BIT_LAST || !sof_seen)
      begin
        win_cnt <= 24'h0;
        fr_cnt  <= 4'h0;
        if (sof_seen)
        begin
          sof_sum   <= win_cnt + 24'h1; // R14
          sum_valid <= 1'b1;
        end
      end
      else
        win_cnt <= win_cnt + 24'h1;
    end
    else if (sof_seen)
      win_cnt <= win_cnt + 24'h1;
  end

  // Linear correction avoids a divider; error stays small near lock.
  logic signed [25:0] sof_err;
  logic signed [35:0] sof_prod;
  assign sof_err  = $signed({2'b00, SOF_WINDOW}) - $signed({2'b00, sof_sum});
  assign sof_prod = 36'(sof_err * $signed({1'b0, `USAS_SYNC_GAIN}));

  always_comb
  begin
    next_step = `USAS_NOM_STEP; // R06
    case (ctrl.sync) // R04
      USAS_SYNC_SYNC:
        if (sum_valid)
          next_step = `USAS_NOM_STEP + sof_prod[31:0]; // R15
      USAS_SYNC_ADAPT:
        next_step = `USAS_NOM_STEP + 32'($signed(trim) * $signed(`USAS_TRIM_UNIT));
      default:
        next_step = `USAS_NOM_STEP;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      step <= `USAS_NOM_STEP;
    else
      step <= next_step;
  end

  // Register access.
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic [31:0] wr_merged;

  function automatic logic [32:0] reg_read(input logic [7:0] a,
                                           input usas_ctrl_s c,
                                           input usas_cfg_s g,
                                           input logic [31:0] st);
    case (a)
      `USAS_REG_CTRL:      return {1'b1, 26'h0, c};
      `USAS_REG_LOW_MARK:  return {1'b1, 25'h0, g.fifo_low_water_mark};
      `USAS_REG_HIGH_MARK: return {1'b1, 25'h0, g.fifo_high_water_mark};
      `USAS_REG_LARGE_LEN: return {1'b1, 24'h0, g.large_packet_length};
      `USAS_REG_NORM_LEN:  return {1'b1, 24'h0, g.normal_packet_length};
      `USAS_REG_SMALL_LEN: return {1'b1, 24'h0, g.small_packet_length};
      `USAS_REG_STATUS:    return {1'b1, st};
      `USAS_REG_SOF_SUM:   return {1'b1, 8'h0, sof_sum};
      `USAS_REG_STEP:      return {1'b1, step};
      default:             return 33'h0;
    endcase
  endfunction

  logic [31:0] status;
  logic [32:0] wr_cur;
  logic [32:0] rd_cur;
  assign status = {in_frame_length, 4'h0, in_band, active, mic_present,
                   1'b0, level[1], 1'b0, level[0]};
  assign wr_cur = reg_read(aw_addr, ctrl, cfg, status);
  assign rd_cur = reg_read(s_axi_araddr, ctrl, cfg, status);
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  for (genvar b = 0; b < 4; b++)
  begin : g_strb
    assign wr_merged[8*b+7:8*b] = w_strb[b] ? w_data[8*b+7:8*b] : wr_cur[8*b+7:8*b];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `USAS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_cur[32] ? `USAS_RESP_OKAY : `USAS_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Status, sum and step words ignore writes but answer OKAY.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= '0;
      cfg  <= {`USAS_LOW_RST, `USAS_HIGH_RST, `USAS_LARGE_RST,
               `USAS_NORM_RST, `USAS_SMALL_RST};
    end
    else if (wr_fire)
    begin
      case (aw_addr) // R17
        `USAS_REG_CTRL:      ctrl <= usas_ctrl_s'(wr_merged[5:0]);
        `USAS_REG_LOW_MARK:  cfg.fifo_low_water_mark <= wr_merged[6:0];
        `USAS_REG_HIGH_MARK: cfg.fifo_high_water_mark <= wr_merged[6:0];
        `USAS_REG_LARGE_LEN: cfg.large_packet_length <= wr_merged[7:0];
        `USAS_REG_NORM_LEN:  cfg.normal_packet_length <= wr_merged[7:0];
        `USAS_REG_SMALL_LEN: cfg.small_packet_length <= wr_merged[7:0];
        default:             ctrl <= ctrl;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `USAS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_cur[31:0];
      s_axi_rresp  <= rd_cur[32] ? `USAS_RESP_OKAY : `USAS_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_out_idle_rx: assert property (!tx_mode |-> audio_serial_out_oe_n ##1 !audio_serial_out) // R02
    else $error("serial out active outside transmit");
  a_pins_quiet: assert property (!active |=> !audio_bit_clock && !audio_word_clock) // R03
    else $error("link clocks run while pins unassigned");
  a_async_fixed: assert property (ctrl.sync == USAS_SYNC_ASYNC |=> step == `USAS_NOM_STEP) // R06
    else $error("async sampling clock was adjusted");
  a_pkt_high: assert property (rx_mode && sof && in_band == USAS_BAND_HIGH
      |=> in_frame_length == $past(cfg.large_packet_length)) // R08
    else $error("large packet not chosen above high mark");
  a_pkt_low: assert property (rx_mode && sof && in_band == USAS_BAND_LOW
      |=> budget == $past(cfg.small_packet_length)) // R08
    else $error("small packet not chosen below low mark");
  a_budget_gate: assert property (in_valid |-> budget != 8'h0 && rx_mode) // R08
    else $error("capture data offered beyond frame grant");
  a_trim_up: assert property (tx_mode && ctrl.sync == USAS_SYNC_ADAPT && sof
      && out_band == USAS_BAND_HIGH && trim < `USAS_TRIM_MAX |=> trim == $past(trim) + 8'sh1) // R12
    else $error("sampling clock not raised above high mark");
  a_trim_hold: assert property (!sof && tx_mode && ctrl.sync == USAS_SYNC_ADAPT
      ##1 tx_mode && ctrl.sync == USAS_SYNC_ADAPT |-> $stable(trim)) // R16
    else $error("trim changed outside start of frame");
  a_sof_sum: assert property (sof && sof_seen && fr_cnt == `USAS_BIT_LAST
      |=> sof_sum == $past(win_cnt) + 24'h1 && sum_valid) // R14
    else $error("frame timing sum not captured at window end");
endmodule

// file: tb/usas_codec_model.sv
// Behavioural codec that sends a changing bit pattern to the capture side.
`timescale 1ns/1ps
module usas_codec_model
(
  input  wire logic bit_clock,  // Bit clock from the block.
  output logic      serial_out  // Serial data to the block.
);
  logic [15:0] pattern = 16'hc3a5;
  initial serial_out = 1'b0;
  // Data moves on the falling edge so the block samples it stable on the rise.
  always @(negedge bit_clock)
  begin
    serial_out <= pattern[15];
    pattern    <= {pattern[14:0], ~pattern[15]};
  end
endmodule

// file: tb/usas_top_tb_top.sv
// Self-checking bench for the audio serial block with rate control.
`timescale 1ns/1ps
`include "usas_defs.svh"
`define CHK(n, e, g) \
  checked++; \
  if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end
module usas_top_tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, sdi, sdo, oe_n, bclk, wclk, mclk, mic;
  logic [7:0] awaddr = 0, araddr = 0, flen;
  logic [31:0] wdata = 0, rdata, got;
  logic [1:0] bresp, rresp, rsp;
  logic sof = 0, in_valid, out_ready, in_ready = 0, out_valid = 0, mic_pin = 0;
  logic [15:0] in_data, out_data = 0;
  int fail_count = 0, checked = 0, n, m, k;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} usas_row_s;
  usas_row_s rows[7] = '{'{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h10, 2'h0}, '{8'h08, 32'h30, 2'h0},
    '{8'h0c, 32'h62, 2'h0}, '{8'h10, 32'h60, 2'h0}, '{8'h14, 32'h5e, 2'h0},
    '{8'h40, 32'h0, 2'h2}};
  always #2.5 aclk = ~aclk;
  usas_top #(.SOF_NOMINAL_CYCLES(200)) usas_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sof(sof), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
    .in_frame_length(flen), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
    .audio_serial_in(sdi), .audio_serial_out(sdo), .audio_serial_out_oe_n(oe_n),
    .audio_bit_clock(bclk), .audio_word_clock(wclk), .audio_master_clock(mclk),
    .microphone_plug_detect(mic_pin), .mic_present(mic));
  usas_codec_model usas_codec_model_i (.bit_clock(bclk), .serial_out(sdi));
  task automatic end_sim();
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, where the slave's outputs have settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(negedge aclk); ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; rsp = bresp;
      @(posedge aclk); if (ta) awvalid <= 0; if (tw) wvalid <= 0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    araddr <= a; arvalid <= 1; rready <= 1;
    do
    begin
      @(negedge aclk); ta = arvalid & arready; tr = rvalid; got = rdata; rsp = rresp;
      @(posedge aclk); if (ta) arvalid <= 0;
    end while (!tr);
  endtask
  task automatic frame();
    sof <= 1;
    @(posedge aclk); sof <= 0;
    repeat (3) @(posedge aclk);
  endtask
  initial
  begin
    #300000 fail_count++;
    end_sim();
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    mic_pin <= 1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      rd(rows[i].a);
      `CHK("reg", rows[i].d, got)
      `CHK("rresp", rows[i].r, rsp)
    end
    `CHK("mic", 1'b1, mic)
    wr(8'h40, 32'h1);
    `CHK("bresp", 2'h2, rsp)
    wr(8'h0c, 32'h71); wr(8'h10, 32'h55); wr(8'h14, 32'h21);
    wr(8'h04, 32'h08); wr(8'h08, 32'h38);
    wr(8'h00, 32'h11);
    frame();
    `CHK("oe_n rx", 1'b1, oe_n)
    `CHK("len empty", 8'h21, flen)
    n = 0;
    repeat (5000)
    begin
      @(posedge aclk);
      n += bclk;
      m += wclk;
      k += mclk;
    end
    `CHK("bit clock runs", 1'b1, n > 0)
    `CHK("word clock runs", 1'b1, m > 0)
    `CHK("master clock runs", 1'b1, k > 0)
    wr(8'h04, 32'h0); wr(8'h08, 32'h0); frame();
    `CHK("len high", 8'h71, flen)
    wr(8'h08, 32'h7f); wr(8'h10, 32'h1); frame();
    `CHK("len mid", 8'h01, flen)
    `CHK("in grant", 1'b1, in_valid)
    in_ready <= 1;
    @(posedge aclk);
    in_ready <= 0;
    @(posedge aclk);
    `CHK("in budget", 1'b0, in_valid)
    rd(8'h20);
    `CHK("step", 32'h1f75104d, got)
    // Frames 201 cycles apart; any full window inside the run sums to 16 of them.
    wr(8'h00, 32'h15);
    repeat (33)
    begin
      sof <= 1;
      @(posedge aclk);
      sof <= 0;
      repeat (200) @(posedge aclk);
    end
    rd(8'h1c);
    `CHK("sof sum", 32'hc90, got)
    rd(8'h20);
    `CHK("sync step", 32'h1f7505fd, got)
    wr(8'h00, 32'h1b); frame();
    `CHK("oe_n tx", 1'b0, oe_n)
    `CHK("out_ready", 1'b1, out_ready)
    out_data <= 16'hffff;
    out_valid <= 1;
    repeat (4) @(posedge aclk);
    out_valid <= 0;
    wr(8'h08, 32'h0); frame();
    rd(8'h20);
    `CHK("trim step", 32'h1f75de76, got)
    n = 0;
    repeat (4500) @(posedge aclk) n += sdo;
    `CHK("serial out", 1'b1, n > 0)
    wr(8'h00, 32'h0b); frame();
    `CHK("oe_n pins off", 1'b1, oe_n)
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    rd(8'h08);
    `CHK("mark rst", 32'h30, got)
    `CHK("mic rst", 1'b1, mic)
    end_sim();
  end
endmodule
